// ---- clk_glitchless_mux.sv ----
`timescale 1ns/10ps

module clk_glitchless_mux
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic ARST_N,
    input  wire logic CE,
    // Sources and request
    input  wire logic lf_level,
    input  wire logic hf_level,
    input  wire logic sel_hf,
    // Result
    output logic      clk_out,
    output logic      on_hf,
    output logic      busy
);

    osc_clk_pkg::mux_state_t state;

    // Switch only while the outgoing and incoming sources are low
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state <= osc_clk_pkg::RUN_LF;
        end
        else if (CE)
        begin
            unique case (state)
                osc_clk_pkg::RUN_LF:
                    if (sel_hf)
                        state <= osc_clk_pkg::DRAIN_LF;
                osc_clk_pkg::DRAIN_LF:
                    if (!lf_level)
                        state <= osc_clk_pkg::WAIT_HF;
                osc_clk_pkg::WAIT_HF:
                    if (!hf_level)
                        state <= osc_clk_pkg::RUN_HF;
                osc_clk_pkg::RUN_HF:
                    if (!sel_hf)
                        state <= osc_clk_pkg::DRAIN_HF;
                osc_clk_pkg::DRAIN_HF:
                    if (!hf_level)
                        state <= osc_clk_pkg::WAIT_LF;
                osc_clk_pkg::WAIT_LF:
                    if (!lf_level)
                        state <= osc_clk_pkg::RUN_LF;
                default:
                    state <= osc_clk_pkg::RUN_LF;
            endcase
        end
    end

    // Gated output, forced low in the gap between sources
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            clk_out <= 1'b0;
        end
        else if (CE)
        begin
            unique case (state)
                osc_clk_pkg::RUN_LF,
                osc_clk_pkg::DRAIN_LF: clk_out <= lf_level;
                osc_clk_pkg::RUN_HF,
                osc_clk_pkg::DRAIN_HF: clk_out <= hf_level;
                default:               clk_out <= 1'b0;
            endcase
        end
    end

    assign on_hf = (state == osc_clk_pkg::RUN_HF)
                 | (state == osc_clk_pkg::DRAIN_HF)
                 | (state == osc_clk_pkg::WAIT_HF);
    assign busy  = (state != osc_clk_pkg::RUN_LF)
                 & (state != osc_clk_pkg::RUN_HF);

endmodule

// ---- osc_clk_asserts.sv ----
`timescale 1ns/10ps
`include "osc_clk_defines.svh"

module osc_clk_asserts
(
    // Clock and bus
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        CE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    // Controls and clocks
    input wire logic        LF_OSC_EN,
    input wire logic        HF_OSC_EN,
    input wire logic        HF_OSC_RC,
    input wire logic        RC_RANGE_HIGH,
    input wire logic        HEAVY_LOAD,
    input wire logic        SYS_CLK,
    input wire logic        INST_CYCLE,
    input wire logic        TIMER_SRC,
    input wire logic        CPU_ON_HF
);
    logic wr;
    logic wr_ctrl;
    logic wr_rng;

    assign wr      = PSEL && PENABLE && PWRITE && CE;
    assign wr_ctrl = wr && PADDR == `OSC_CTRL_ADDR;
    assign wr_rng  = wr && PADDR == `OSC_RANGE_ADDR;

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_hf_start: assert property (
        wr_ctrl && PWDATA[1] |-> ##[1:2] HF_OSC_EN)
        else $error("fast oscillator not started");
    chk_rc_type: assert property (
        wr_ctrl |-> ##2 HF_OSC_RC == $past(PWDATA[3], 2))
        else $error("oscillator type not applied");
    chk_heavy_gain: assert property (
        wr_ctrl |-> ##2 HEAVY_LOAD == $past(PWDATA[0], 2))
        else $error("heavy load not applied");
    chk_rc_range: assert property (
        wr_rng |-> ##2 RC_RANGE_HIGH == $past(PWDATA[1], 2))
        else $error("range not applied");
    chk_timer_source: assert property (
        wr_rng |-> ##2 TIMER_SRC == $past(PWDATA[0], 2))
        else $error("timer source not applied");
    chk_reset_off: assert property (@(posedge CLK) disable iff (1'b0)
        !ARST_N |-> !HF_OSC_EN && !CPU_ON_HF && !SYS_CLK)
        else $error("outputs active in reset");
    chk_slow_runs: assert property (
        $past(ARST_N) |-> LF_OSC_EN)
        else $error("slow oscillator stopped");
    chk_stop_deferred: assert property (
        wr_ctrl && PWDATA[2:1] == 2'b00 && CPU_ON_HF && HF_OSC_EN
        |=> HF_OSC_EN [*2])
        else $error("fast oscillator stopped too early");
    chk_inst_spacing: assert property (
        INST_CYCLE |=> !INST_CYCLE [*3])
        else $error("instruction pulses too close");
    chk_no_runt: assert property (
        $rose(SYS_CLK) |=> SYS_CLK [*3])
        else $error("truncated system clock pulse");

    cov_to_fast: cover property ($rose(CPU_ON_HF));
    cov_to_slow: cover property ($fell(CPU_ON_HF));
    cov_fast_off: cover property ($fell(HF_OSC_EN));
endmodule

bind osc_clock_control osc_clk_asserts u_osc_clk_asserts
(
    .CLK, .ARST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .LF_OSC_EN, .HF_OSC_EN, .HF_OSC_RC, .RC_RANGE_HIGH, .HEAVY_LOAD,
    .SYS_CLK, .INST_CYCLE, .TIMER_SRC, .CPU_ON_HF
);

// ---- osc_clk_defines.svh ----
`ifndef OSC_CLK_DEFINES_SVH
`define OSC_CLK_DEFINES_SVH

// Register byte addresses
`define OSC_CTRL_ADDR      12'h014
`define OSC_RANGE_ADDR     12'h3C4
`define OSC_STATUS_ADDR    12'h018
`define OSC_ADDR_W         12

// Oscillator control fields
`define OSC_HEAVY_BIT      0
`define OSC_HF_EN_BIT      1
`define OSC_CPU_SEL_BIT    2
`define OSC_HF_RC_BIT      3
`define OSC_CTRL_RESET     4'h0

// Range and timer source fields
`define OSC_TSRC_BIT       0
`define OSC_RANGE_BIT      1
`define OSC_RANGE_RESET    2'h0

// Status fields
`define OSC_ST_ON_HF_BIT   0
`define OSC_ST_BUSY_BIT    1
`define OSC_ST_PEND_BIT    2

// Oscillator periods per instruction cycle
`define OSC_SYS_DIV        4

`endif

// ---- osc_clk_pkg.sv ----
package osc_clk_pkg;

    typedef struct packed {
        logic hf_rc;
        logic cpu_sel;
        logic hf_en;
        logic heavy_load;
    } osc_ctrl_t;

    typedef struct packed {
        logic range_high;
        logic timer_src;
    } rc_range_t;

    typedef enum logic [2:0] {
        RUN_LF,
        DRAIN_LF,
        WAIT_HF,
        RUN_HF,
        DRAIN_HF,
        WAIT_LF
    } mux_state_t;

endpackage

// ---- osc_clock_control.sv ----
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "osc_clk_defines.svh"

module osc_clock_control
#(
    parameter int DIV = `OSC_SYS_DIV
)
(
    // Clock, reset and enable
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Oscillator levels
    input  wire logic        LF_OSC_LEVEL,
    input  wire logic        HF_OSC_LEVEL,
    // Oscillator controls
    output logic             LF_OSC_EN,
    output logic             HF_OSC_EN,
    output logic             HF_OSC_RC,
    output logic             RC_RANGE_HIGH,
    output logic             HEAVY_LOAD,
    // Clocks to the core and peripherals
    output logic             SYS_CLK,
    output logic             INST_CYCLE,
    output logic             PERIPH_CLK,
    output logic             TIMER_CLK,
    output logic             TIMER_SRC,
    output logic             CPU_ON_HF
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    osc_clk_pkg::osc_ctrl_t ctrl;
    osc_clk_pkg::osc_ctrl_t next_ctrl;
    osc_clk_pkg::rc_range_t range;
    logic                   pending_off;
    logic                   mux_clk;
    logic                   mux_on_hf;
    logic                   mux_busy;
    logic                   mux_prev;
    logic                   mux_rise;
    logic [CW-1:0]          div_cnt;
    logic                   setup;
    logic                   access_wr;
    logic                   hit_ctrl;
    logic                   hit_range;
    logic                   hit_status;
    logic                   mapped;
    logic [3:0]             status;

    // APB decode
    assign setup      = PSEL & ~PENABLE;
    assign access_wr  = PSEL & PENABLE & PWRITE;
    assign hit_ctrl   = (PADDR == `OSC_CTRL_ADDR);
    assign hit_range  = (PADDR == `OSC_RANGE_ADDR);
    assign hit_status = (PADDR == `OSC_STATUS_ADDR);
    assign mapped     = hit_ctrl | hit_range | hit_status;
    assign PREADY     = 1'b1;
    assign next_ctrl  = osc_clk_pkg::osc_ctrl_t'(PWDATA[3:0]);

    assign status = {1'b0,
                     pending_off,
                     mux_busy,
                     mux_on_hf};

    // Read data and error captured in the setup cycle
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (CE && setup)
        begin
            PSLVERR <= ~mapped;
            if (!PWRITE && hit_ctrl)
                PRDATA <= {28'h000_0000, ctrl};
            else if (!PWRITE && hit_range)
                PRDATA <= {30'h0000_0000, range};
            else if (!PWRITE && hit_status)
                PRDATA <= {28'h000_0000, status};
            else
                PRDATA <= 32'h0000_0000;
        end
    end

    // Oscillator control register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl <= osc_clk_pkg::osc_ctrl_t'(`OSC_CTRL_RESET);
        end
        else if (CE && access_wr && hit_ctrl)
        begin
            ctrl.hf_en      <= next_ctrl.hf_en;
            ctrl.cpu_sel    <= next_ctrl.cpu_sel;
            ctrl.hf_rc      <= next_ctrl.hf_rc;
            ctrl.heavy_load <= next_ctrl.heavy_load;
        end
    end

    // Range and timer source register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            range <= osc_clk_pkg::rc_range_t'(`OSC_RANGE_RESET);
        end
        else if (CE && access_wr && hit_range)
        begin
            range.range_high <= PWDATA[`OSC_RANGE_BIT];
            range.timer_src  <= PWDATA[`OSC_TSRC_BIT];
        end
    end

    // Deferred stop of the fast oscillator; a new request wins
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pending_off <= 1'b0;
        end
        else if (CE)
        begin
            if (access_wr && hit_ctrl && ctrl.hf_en
                && !next_ctrl.hf_en && !next_ctrl.cpu_sel
                && (ctrl.cpu_sel || mux_on_hf))
                pending_off <= 1'b1;
            else if (!mux_on_hf && !mux_busy && INST_CYCLE)
                pending_off <= 1'b0;
        end
    end

    // Glitch-free source switch
    clk_glitchless_mux u_mux
    (
        .CLK      (CLK),
        .ARST_N   (ARST_N),
        .CE       (CE),
        .lf_level (LF_OSC_LEVEL),
        .hf_level (HF_OSC_LEVEL),
        .sel_hf   (ctrl.cpu_sel),
        .clk_out  (mux_clk),
        .on_hf    (mux_on_hf),
        .busy     (mux_busy)
    );

    assign mux_rise = mux_clk & ~mux_prev;

    // Divide selected oscillator into instruction cycles
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mux_prev   <= 1'b0;
            div_cnt    <= '0;
            SYS_CLK    <= 1'b0;
            INST_CYCLE <= 1'b0;
        end
        else if (CE)
        begin
            mux_prev   <= mux_clk;
            INST_CYCLE <= 1'b0;
            if (mux_rise)
            begin
                if (div_cnt == CW'(DIV - 1))
                begin
                    div_cnt    <= '0;
                    INST_CYCLE <= 1'b1;
                end
                else
                begin
                    div_cnt <= div_cnt + CW'(1);
                end
                SYS_CLK <= (div_cnt < CW'(DIV / 2));
            end
        end
    end

    // Oscillator controls and peripheral clocks
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            LF_OSC_EN     <= 1'b0;
            HF_OSC_EN     <= 1'b0;
            HF_OSC_RC     <= 1'b0;
            RC_RANGE_HIGH <= 1'b0;
            HEAVY_LOAD    <= 1'b0;
            PERIPH_CLK    <= 1'b0;
            TIMER_CLK     <= 1'b0;
            TIMER_SRC     <= 1'b0;
            CPU_ON_HF     <= 1'b0;
        end
        else if (CE)
        begin
            LF_OSC_EN     <= 1'b1;
            HF_OSC_EN     <= ctrl.hf_en | pending_off;
            HF_OSC_RC     <= ctrl.hf_rc;
            RC_RANGE_HIGH <= range.range_high;
            HEAVY_LOAD    <= ctrl.heavy_load;
            PERIPH_CLK    <= LF_OSC_LEVEL;
            TIMER_SRC     <= range.timer_src;
            TIMER_CLK     <= range.timer_src ? SYS_CLK
                                             : LF_OSC_LEVEL;
            CPU_ON_HF     <= mux_on_hf & ~mux_busy;
        end
    end

endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "osc_clk_defines.svh"

module tb_top;
    logic        CLK, ARST_N, CE, PSEL, PENABLE, PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic        PREADY, PSLVERR, LF_OSC_LEVEL, HF_OSC_LEVEL, er;
    logic        LF_OSC_EN, HF_OSC_EN, HF_OSC_RC, RC_RANGE_HIGH, HEAVY_LOAD;
    logic        SYS_CLK, INST_CYCLE, PERIPH_CLK, TIMER_CLK, TIMER_SRC;
    logic        CPU_ON_HF;
    int          fails, checks_done, lf_cnt;

    osc_clock_control u_osc_clock_control
    (
        .CLK, .ARST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .LF_OSC_LEVEL, .HF_OSC_LEVEL,
        .LF_OSC_EN, .HF_OSC_EN, .HF_OSC_RC, .RC_RANGE_HIGH, .HEAVY_LOAD,
        .SYS_CLK, .INST_CYCLE, .PERIPH_CLK, .TIMER_CLK, .TIMER_SRC,
        .CPU_ON_HF
    );

    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Oscillator levels, stopped ones held low
    always @(posedge CLK)
    begin
        lf_cnt <= lf_cnt + 1;
        LF_OSC_LEVEL <= LF_OSC_EN & lf_cnt[2];
        HF_OSC_LEVEL <= HF_OSC_EN & ~HF_OSC_LEVEL;
    end

    task automatic end_of_test;
        $display("fails=%0d checks_done=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge CLK);
            if (PREADY === 1'b1)
                break;
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 20)
        begin
            fails++;
            end_of_test;
        end
    endtask

    task automatic wait_sig(input bit s, input logic v);
        int n;
        for (n = 0; n < 500; n++)
        begin
            @(posedge CLK);
            if ((s ? HF_OSC_EN : CPU_ON_HF) === v)
                break;
        end
        if (n == 500)
        begin
            fails++;
            end_of_test;
        end
    endtask

    // Period of the system clock and pulses within it
    task automatic meas(input int exp);
        int n;
        int ip;
        logic p;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            ip = 0;
            do
            begin
                p = SYS_CLK;
                @(posedge CLK);
                n++;
                ip += int'(INST_CYCLE === 1'b1);
            end while (!(SYS_CLK === 1'b1 && p === 1'b0) && n < 200);
        end
        chk(n, exp);
        chk(ip, 32'h1);
    endtask

    task automatic t_reset;
        apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `OSC_RANGE_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk({LF_OSC_EN, HF_OSC_EN, CPU_ON_HF, HF_OSC_RC}, 32'h8);
        chk({RC_RANGE_HIGH, HEAVY_LOAD, TIMER_SRC}, 32'h0);
    endtask

    task automatic t_ctrl;
        logic [3:0] tbl [5] = '{4'h1, 4'hA, 4'h2, 4'hB, 4'h0};
        foreach (tbl[i])
        begin
            apb(1'b1, `OSC_CTRL_ADDR, {28'h0, tbl[i]});
            apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
            chk(rd, {28'h0, tbl[i]});
            chk({HF_OSC_RC, HF_OSC_EN, HEAVY_LOAD},
                {tbl[i][3], tbl[i][1:0]});
        end
    endtask

    task automatic t_range;
        logic [1:0] tbl [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
        foreach (tbl[i])
        begin
            apb(1'b1, `OSC_RANGE_ADDR, {30'h0, tbl[i]});
            apb(1'b0, `OSC_RANGE_ADDR, 32'h0);
            chk(rd, {30'h0, tbl[i]});
            chk({RC_RANGE_HIGH, TIMER_SRC}, tbl[i]);
        end
    endtask

    task automatic t_unmapped;
        apb(1'b1, 12'h020, 32'h0000000F);
        chk(er, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_switch;
        apb(1'b1, `OSC_CTRL_ADDR, 32'h2);
        repeat (40) @(posedge CLK);
        apb(1'b1, `OSC_CTRL_ADDR, 32'h6);
        wait_sig(1'b0, 1'b1);
        chk(CPU_ON_HF, 32'h1);
        apb(1'b0, `OSC_STATUS_ADDR, 32'h0);
        chk(rd, 32'h1);
        meas(8);
        apb(1'b1, `OSC_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge CLK);
        chk(HF_OSC_EN, 32'h1);
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b1, 1'b0);
        chk({CPU_ON_HF, HF_OSC_EN}, 32'h0);
        apb(1'b0, `OSC_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
        meas(32);
    endtask

    // Peripheral and timer clocks follow their sources a cycle late
    task automatic t_clocks(input logic src);
        logic lf;
        logic sc;
        apb(1'b1, `OSC_RANGE_ADDR, {31'h0, src});
        repeat (2) @(posedge CLK);
        for (int k = 0; k < 40; k++)
        begin
            lf = LF_OSC_LEVEL;
            sc = SYS_CLK;
            @(posedge CLK);
            chk(PERIPH_CLK, lf);
            chk(TIMER_CLK, src ? sc : lf);
        end
    endtask

    // Clock enable low holds the clock outputs
    task automatic t_freeze;
        logic [3:0] snap;
        int         n;
        int         moves;
        moves = 0;
        for (n = 0; n < 100; n++)
        begin
            @(posedge CLK);
            if (INST_CYCLE === 1'b1)
                break;
        end
        CE <= 1'b0;
        @(posedge CLK);
        snap = {SYS_CLK, INST_CYCLE, PERIPH_CLK, TIMER_CLK};
        repeat (40)
        begin
            @(posedge CLK);
            moves += int'(snap !== {SYS_CLK, INST_CYCLE,
                                    PERIPH_CLK, TIMER_CLK});
        end
        CE <= 1'b1;
        chk(n < 100, 32'h1);
        chk(moves, 32'h0);
    endtask

    initial
    begin
        ARST_N = 1'b1;
        CE = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        fails = 0;
        checks_done = 0;
        #1;
        ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        t_reset;
        t_ctrl;
        t_range;
        t_clocks(1'b0);
        t_clocks(1'b1);
        t_unmapped;
        t_switch;
        t_freeze;
        end_of_test;
    end
endmodule
